//--- src/rss_defines.svh
// named constants of the reset and start-up sequencer
// assumes a 100 MHz core clock and word-indexed classic wishbone access
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

// word indices, byte address is four times the index
`define RSS_CFG_INDEX 14'h2007
`define RSS_TEST_LO 14'h2000
`define RSS_TEST_HI 14'h3fff
`define RSS_STATUS_INDEX 14'h0001

// configuration word layout
`define RSS_CFG_W 14
`define RSS_CFG_RESET 14'h3fff
`define RSS_CFG_READ_MASK 14'h3f7f
`define RSS_OSC_HI 1
`define RSS_OSC_LO 0
`define RSS_WDT_BIT 2
`define RSS_POWERUP_TIMER_N_BIT 3
`define RSS_CP_HI 5
`define RSS_CP_LO 4
`define RSS_BOR_BIT 6
`define RSS_OSC_RC 2'h3
`define RSS_CP_NONE 2'h3
`define RSS_CP_HALF 2'h2
`define RSS_CP_QUARTER 2'h1
`define RSS_PROT_HALF 11'h400
`define RSS_PROT_QUARTER 11'h200
`define RSS_PROT_ALL 11'h000

// status word layout
`define RSS_ST_TO 0
`define RSS_ST_PD 1
`define RSS_ST_CAUSE_LO 2
`define RSS_ST_CAUSE_HI 4

// timing
`define RSS_CLK_NS 10
`define RSS_POWERUP_TIMER_MS 72
`define RSS_POWERUP_TIMER_CYC (`RSS_POWERUP_TIMER_MS * 1000000 / `RSS_CLK_NS)
`define RSS_OST_CYC 1024
`define RSS_BOR_MIN_NS 100
`define RSS_BOR_MIN_CYC ((`RSS_BOR_MIN_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_MASTER_CLEAR_PIN_MIN_NS 2000
`define RSS_MASTER_CLEAR_PIN_MIN_CYC ((`RSS_MASTER_CLEAR_PIN_MIN_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)

`endif

//--- src/rss_pkg.sv
// types of the reset and start-up sequencer
// assumes rss_defines.svh for field widths
`include "rss_defines.svh"

package rss_pkg;

  typedef enum logic [2:0] {
    ST_POWER, ST_HOLD, ST_POWERUP_TIMER, ST_OST, ST_RUN
  } rss_state_type;

  typedef enum logic [2:0] {
    KIND_POR, KIND_MASTER_CLEAR_PIN_RUN, KIND_MASTER_CLEAR_PIN_SLEEP,
    KIND_WDT_RUN, KIND_WDT_WAKE, KIND_BOR
  } rss_kind_type;

  typedef struct packed {
    rss_state_type state;
    rss_kind_type kind;
    logic [`RSS_CFG_W-1:0] cfg;
    logic to_flag;
    logic pd_flag;
    logic master_clear_pin_s1, master_clear_pin_s2;
    logic pg_s1, pg_s2;
    logic bl_s1, bl_s2;
    logic osc_s1, osc_s2, osc_s3;
    logic prog_s1, prog_s2;
    logic [7:0] master_clear_pin_cnt;
    logic [7:0] bor_cnt;
    logic master_clear_pin_low;
    logic bor_low;
    logic [23:0] tmr;
    logic [10:0] oscillator_startup_timer;
    logic hold;
    logic reg_init;
    logic prot_on;
    logic [10:0] prot_start;
    logic ack;
    logic [31:0] dat;
  } rss_regs_type;

endpackage : rss_pkg

//--- src/rss_reset_sequencer.sv
// reset and start-up sequencer with a classic wishbone slave
// assumes pins are asynchronous, watchdog and sleep come from core_clk logic
`include "rss_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module rss_reset_sequencer
  import rss_pkg::*;
#(
  parameter int POWERUP_TIMER_CYCLES = `RSS_POWERUP_TIMER_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [15:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [3:0] SEL_I,
  input wire logic WE_I,
  input wire logic STB_I,
  input wire logic CYC_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic POWER_GOOD,
  input wire logic SUPPLY_LOW,
  input wire logic MASTER_CLEAR_PIN_N,
  input wire logic OSC_IN,
  input wire logic PROG_MODE,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic SLEEPING,
  output logic CORE_HOLD,
  output logic REG_INIT,
  output logic TIMEOUT_FLAG,
  output logic POWERDOWN_FLAG,
  output logic [1:0] OSC_MODE,
  output logic WATCHDOG_ENABLE,
  output logic BROWNOUT_ENABLE,
  output logic PROTECT_ON,
  output logic [10:0] PROTECT_START
);

  // -----------------------------------------------------------
  // constants sized to what they meet
  // -----------------------------------------------------------
  localparam logic [23:0] POWERUP_TIMER_LAST = 24'(POWERUP_TIMER_CYCLES - 1);
  localparam logic [10:0] OST_LAST = 11'(`RSS_OST_CYC - 1);
  localparam logic [7:0] MASTER_CLEAR_PIN_MIN = 8'(`RSS_MASTER_CLEAR_PIN_MIN_CYC);
  localparam logic [7:0] BOR_MIN = 8'(`RSS_BOR_MIN_CYC);

  rss_regs_type st;
  rss_regs_type nx;

  logic [13:0] idx;
  logic bus_go;
  logic cfg_hit;
  logic [13:0] wmask;
  logic [31:0] stat;
  logic osc_edge;
  logic bor_fuse;
  logic powerup_timer_on;
  logic xtal;
  logic bor_trip;
  logic brown;
  logic release_ok;
  logic wdt_event;

  // flags per reset kind, {timeout, powerdown}
  function automatic logic [1:0] rss_flags(
    input rss_kind_type k,
    input logic [1:0] cur
  );
    logic [1:0] f;
    f = cur;
    case (k)
      KIND_POR: f = 2'h3;
      KIND_BOR: f = 2'h3;
      KIND_MASTER_CLEAR_PIN_RUN: f = cur;
      KIND_MASTER_CLEAR_PIN_SLEEP: f = 2'h2;
      KIND_WDT_RUN: f = 2'h1;
      KIND_WDT_WAKE: f = 2'h0;
      default: f = cur;
    endcase
    return f;
  endfunction : rss_flags

  // -----------------------------------------------------------
  // derived terms
  // -----------------------------------------------------------
  // fuse decode and filtered sources
  assign bor_fuse = st.cfg[`RSS_BOR_BIT];
  assign powerup_timer_on = !st.cfg[`RSS_POWERUP_TIMER_N_BIT] || bor_fuse;
  assign xtal = st.cfg[`RSS_OSC_HI:`RSS_OSC_LO] != `RSS_OSC_RC;
  assign bor_trip = bor_fuse && st.bor_low;
  assign brown = bor_fuse && st.bl_s2;
  assign release_ok = !st.master_clear_pin_low && !brown;
  assign wdt_event = WATCHDOG_TIMEOUT && st.cfg[`RSS_WDT_BIT];
  assign osc_edge = st.osc_s2 && !st.osc_s3;

  // bus decode, test space only in programming mode
  assign idx = ADR_I[15:2];
  assign bus_go = CYC_I && STB_I && !st.ack;
  assign cfg_hit = st.prog_s2 && idx >= `RSS_TEST_LO && idx == `RSS_CFG_INDEX;
  assign wmask = {{6{SEL_I[1]}}, {8{SEL_I[0]}}};

  // status word: flags and cause
  always_comb begin
    stat = 32'h0;
    stat[`RSS_ST_TO] = st.to_flag;
    stat[`RSS_ST_PD] = st.pd_flag;
    stat[`RSS_ST_CAUSE_HI:`RSS_ST_CAUSE_LO] = st.kind;
  end

  // -----------------------------------------------------------
  // next state
  // -----------------------------------------------------------
  always_comb begin
    nx = st;
    // two-stage synchronisers
    nx.master_clear_pin_s1 = MASTER_CLEAR_PIN_N;
    nx.master_clear_pin_s2 = st.master_clear_pin_s1;
    nx.pg_s1 = POWER_GOOD;
    nx.pg_s2 = st.pg_s1;
    nx.bl_s1 = SUPPLY_LOW;
    nx.bl_s2 = st.bl_s1;
    nx.osc_s1 = OSC_IN;
    nx.osc_s2 = st.osc_s1;
    nx.osc_s3 = st.osc_s2;
    nx.prog_s1 = PROG_MODE;
    nx.prog_s2 = st.prog_s1;

    // master clear noise filter
    if (st.master_clear_pin_s2) begin
      nx.master_clear_pin_cnt = 8'h00;
    end else if (st.master_clear_pin_cnt != MASTER_CLEAR_PIN_MIN) begin
      nx.master_clear_pin_cnt = st.master_clear_pin_cnt + 8'h01;
    end
    nx.master_clear_pin_low = !st.master_clear_pin_s2 && st.master_clear_pin_cnt == MASTER_CLEAR_PIN_MIN;

    // brownout duration filter
    if (!st.bl_s2) begin
      nx.bor_cnt = 8'h00;
    end else if (st.bor_cnt != BOR_MIN) begin
      nx.bor_cnt = st.bor_cnt + 8'h01;
    end
    nx.bor_low = st.bl_s2 && st.bor_cnt == BOR_MIN;

    // code protection decode
    case (st.cfg[`RSS_CP_HI:`RSS_CP_LO])
      `RSS_CP_NONE: begin
        nx.prot_on = 1'b0;
        nx.prot_start = `RSS_PROT_ALL;
      end
      `RSS_CP_HALF: begin
        nx.prot_on = 1'b1;
        nx.prot_start = `RSS_PROT_HALF;
      end
      `RSS_CP_QUARTER: begin
        nx.prot_on = 1'b1;
        nx.prot_start = `RSS_PROT_QUARTER;
      end
      default: begin
        nx.prot_on = 1'b1;
        nx.prot_start = `RSS_PROT_ALL;
      end
    endcase

    // wishbone slave, one wait state, unmapped reads zero
    nx.ack = bus_go;
    nx.dat = 32'h0;
    if (bus_go && !WE_I) begin
      if (idx == `RSS_STATUS_INDEX) begin
        nx.dat = stat;
      end else if (cfg_hit) begin
        nx.dat = {18'h0, st.cfg & `RSS_CFG_READ_MASK};
      end
    end
    // programming only clears bits
    if (bus_go && WE_I && cfg_hit) begin
      nx.cfg = st.cfg & ~(wmask & ~DAT_I[13:0]);
    end

    // sequencer
    case (st.state)
      ST_POWER: begin
        if (st.pg_s2) begin
          nx.state = ST_HOLD;
          nx.kind = KIND_POR;
          {nx.to_flag, nx.pd_flag} = rss_flags(KIND_POR, 2'h3);
        end
      end
      ST_HOLD: begin
        if (bor_trip && st.kind != KIND_POR) begin
          nx.kind = KIND_BOR;
          {nx.to_flag, nx.pd_flag} = rss_flags(KIND_BOR, 2'h3);
        end else if (release_ok) begin
          nx.tmr = 24'h0;
          nx.oscillator_startup_timer = 11'h0;
          if ((st.kind == KIND_POR || st.kind == KIND_BOR) && powerup_timer_on) begin
            nx.state = ST_POWERUP_TIMER;
          end else if (st.kind == KIND_POR && xtal) begin
            nx.state = ST_OST;
          end else begin
            nx.state = ST_RUN;
          end
        end
      end
      ST_POWERUP_TIMER: begin
        if (brown) begin
          nx.state = ST_HOLD;
          nx.kind = KIND_BOR;
          {nx.to_flag, nx.pd_flag} = rss_flags(KIND_BOR, 2'h3);
        end else if (st.tmr == POWERUP_TIMER_LAST) begin
          nx.oscillator_startup_timer = 11'h0;
          nx.state = (st.kind == KIND_POR && xtal) ? ST_OST : ST_RUN;
        end else begin
          nx.tmr = st.tmr + 24'h1;
        end
      end
      ST_OST: begin
        if (st.master_clear_pin_low) begin
          nx.state = ST_HOLD;
          nx.kind = KIND_MASTER_CLEAR_PIN_RUN;
        end else if (osc_edge) begin
          if (st.oscillator_startup_timer == OST_LAST) begin
            nx.state = ST_RUN;
          end else begin
            nx.oscillator_startup_timer = st.oscillator_startup_timer + 11'h1;
          end
        end
      end
      ST_RUN: begin
        if (bor_trip) begin
          nx.state = ST_HOLD;
          nx.kind = KIND_BOR;
          {nx.to_flag, nx.pd_flag} = rss_flags(KIND_BOR, 2'h3);
        end else if (st.master_clear_pin_low) begin
          nx.state = ST_HOLD;
          nx.kind = SLEEPING ? KIND_MASTER_CLEAR_PIN_SLEEP : KIND_MASTER_CLEAR_PIN_RUN;
          {nx.to_flag, nx.pd_flag} = rss_flags(nx.kind, {st.to_flag, st.pd_flag});
        end else if (wdt_event && SLEEPING) begin
          nx.kind = KIND_WDT_WAKE;
          nx.oscillator_startup_timer = 11'h0;
          nx.state = xtal ? ST_OST : ST_RUN;
          {nx.to_flag, nx.pd_flag} = rss_flags(KIND_WDT_WAKE, 2'h0);
        end else if (wdt_event) begin
          nx.state = ST_HOLD;
          nx.kind = KIND_WDT_RUN;
          {nx.to_flag, nx.pd_flag} = rss_flags(KIND_WDT_RUN, 2'h1);
        end
      end
      default: begin
        nx.state = ST_POWER;
      end
    endcase

    // registered hold and init outputs; a watchdog wake from sleep may hold but never sees init
    nx.hold = nx.state != ST_RUN;
    nx.reg_init = nx.hold && nx.kind != KIND_WDT_WAKE;
  end

  // -----------------------------------------------------------
  // state register
  // -----------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      st <= '0;
      st.cfg <= `RSS_CFG_RESET;
      st.to_flag <= 1'b1;
      st.pd_flag <= 1'b1;
      st.hold <= 1'b1;
      st.reg_init <= 1'b1;
      st.master_clear_pin_s1 <= 1'b1; // clear pin syncs start released, no false edge
      st.master_clear_pin_s2 <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  // outputs straight from the state register
  assign DAT_O = st.dat;
  assign ACK_O = st.ack;
  assign CORE_HOLD = st.hold;
  assign REG_INIT = st.reg_init;
  assign TIMEOUT_FLAG = st.to_flag;
  assign POWERDOWN_FLAG = st.pd_flag;
  assign OSC_MODE = st.cfg[`RSS_OSC_HI:`RSS_OSC_LO];
  assign WATCHDOG_ENABLE = st.cfg[`RSS_WDT_BIT];
  assign BROWNOUT_ENABLE = st.cfg[`RSS_BOR_BIT];
  assign PROTECT_ON = st.prot_on;
  assign PROTECT_START = st.prot_start;

  // -----------------------------------------------------------
  // checks
  // -----------------------------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);

  property p_cfg_locked;
    !st.prog_s2 |=> $stable(st.cfg);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("config changed outside programming");

  property p_ost_only_xtal;
    st.state == ST_OST |-> xtal && (st.kind == KIND_POR || st.kind == KIND_WDT_WAKE);
  endproperty
  a_ost_only_xtal: assert property (p_ost_only_xtal) else $error("start-up count in wrong case");

  property p_wdt_off;
    st.state == ST_RUN && WATCHDOG_TIMEOUT && !st.cfg[`RSS_WDT_BIT] && !bor_trip && !st.master_clear_pin_low
      |=> st.state == ST_RUN && !CORE_HOLD;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("disabled watchdog caused reset");

  property p_powerup_timer_taken;
    st.state == ST_HOLD && (st.kind == KIND_POR || st.kind == KIND_BOR) && powerup_timer_on && release_ok
      && !bor_trip |=> st.state == ST_POWERUP_TIMER && st.tmr == 24'h0;
  endproperty
  a_powerup_timer_taken: assert property (p_powerup_timer_taken) else $error("power-up timer skipped");

  property p_direct_release;
    st.state == ST_HOLD && st.kind == KIND_POR && !powerup_timer_on && !xtal && release_ok
      |=> st.state == ST_RUN && !CORE_HOLD;
  endproperty
  a_direct_release: assert property (p_direct_release) else $error("release delayed");

  property p_powerup_timer_count;
    st.state == ST_POWERUP_TIMER && st.tmr != POWERUP_TIMER_LAST && !brown
      |=> st.state == ST_POWERUP_TIMER && st.tmr == $past(st.tmr) + 24'h1 && CORE_HOLD;
  endproperty
  a_powerup_timer_count: assert property (p_powerup_timer_count) else $error("power-up timer miscounts");

  property p_ost_early;
    st.state == ST_OST && st.oscillator_startup_timer != OST_LAST |=> st.state != ST_RUN;
  endproperty
  a_ost_early: assert property (p_ost_early) else $error("start-up count ended early");

  property p_master_clear_pin_glitch;
    $fell(st.master_clear_pin_s2) |=> !st.master_clear_pin_low [*8];
  endproperty
  a_master_clear_pin_glitch: assert property (p_master_clear_pin_glitch) else $error("short clear pulse accepted");

  property p_bor_short;
    $rose(st.bl_s2) |=> !st.bor_low [*8];
  endproperty
  a_bor_short: assert property (p_bor_short) else $error("short dip caused brownout");

  property p_powerup_timer_restart;
    st.state == ST_POWERUP_TIMER && brown |=> st.state == ST_HOLD && st.kind == KIND_BOR && TIMEOUT_FLAG;
  endproperty
  a_powerup_timer_restart: assert property (p_powerup_timer_restart) else $error("dip did not restart timer");

  property p_wake_flags;
    st.state == ST_RUN && wdt_event && SLEEPING && !bor_trip && !st.master_clear_pin_low
      |=> !TIMEOUT_FLAG && !POWERDOWN_FLAG && !st.reg_init;
  endproperty
  a_wake_flags: assert property (p_wake_flags) else $error("wake-up flags wrong");

  property p_por_once;
    st.state != ST_POWER |=> st.state != ST_POWER;
  endproperty
  a_por_once: assert property (p_por_once) else $error("power-on detect re-entered");

  c_powerup_timer_done: cover property (st.state == ST_POWERUP_TIMER ##1 st.state == ST_RUN);
  c_ost_done: cover property (st.state == ST_OST ##1 st.state == ST_RUN);
  c_wdt_wake: cover property (st.state == ST_RUN ##1 st.kind == KIND_WDT_WAKE);
  c_cfg_write: cover property (bus_go && WE_I && cfg_hit);

endmodule : rss_reset_sequencer

`default_nettype wire

//--- tb/rss_pin_model.sv
// pin-side model: supply monitor, master clear pin and crystal
// assumes the bench requests pin levels; the crystal runs free once fitted
`timescale 1ns/1ps
`default_nettype none

module rss_pin_model (
  input wire logic CORE_CLK,
  input wire logic supply_up,
  input wire logic supply_dip,
  input wire logic clear_req,
  output logic POWER_GOOD,
  output logic SUPPLY_LOW,
  output logic MASTER_CLEAR_PIN_N,
  output logic OSC_IN
);
  // ----------------------------------------
  // supply and master clear levels
  // ----------------------------------------
  // levels follow requests just after a clock edge
  always @(posedge CORE_CLK) begin
    POWER_GOOD <= supply_up;
    SUPPLY_LOW <= supply_dip;
    MASTER_CLEAR_PIN_N <= ~clear_req;
  end
  // crystal of 40 ns period, phase unrelated to the core clock
  initial begin
    OSC_IN = 1'b0;
    #3;
    forever #20 OSC_IN = ~OSC_IN;
  end
endmodule : rss_pin_model

`default_nettype wire

//--- tb/rss_reset_sequencer_bench.sv
// self-checking bench of the reset and start-up sequencer
// assumes rss_defines.svh and rss_pkg compiled first, power-up delay shortened
`timescale 1ns/1ps
`default_nettype none

module rss_reset_sequencer_bench;
  localparam int POWERUP_TIMER = 50;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, stb = 1'b0, cyc = 1'b0;
  logic prog = 1'b0, wdt = 1'b0, slp = 1'b0, sup = 1'b0, dip = 1'b0, clr = 1'b0;
  logic [15:0] adr = '0;
  logic [31:0] wdat = '0, rd, dat_o;
  logic [3:0] sel = '0;
  logic ack, hold, init, to_f, pd_f, wen, ben, pon, pg, sl, mn, oi;
  logic [1:0] osc;
  logic [10:0] pst;
  int n_mismatch = 0, checked = 0, cyc_cnt = 0, hcnt = 0;
  integer seed = 32'h258b;

  rss_pin_model pins (.CORE_CLK(clk), .supply_up(sup), .supply_dip(dip), .clear_req(clr),
    .POWER_GOOD(pg), .SUPPLY_LOW(sl), .MASTER_CLEAR_PIN_N(mn), .OSC_IN(oi));

  rss_reset_sequencer #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER)) DUT (.CORE_CLK(clk), .RESET(rst), .ADR_I(adr),
    .DAT_I(wdat), .SEL_I(sel), .WE_I(we), .STB_I(stb), .CYC_I(cyc), .DAT_O(dat_o), .ACK_O(ack),
    .POWER_GOOD(pg), .SUPPLY_LOW(sl), .MASTER_CLEAR_PIN_N(mn), .OSC_IN(oi), .PROG_MODE(prog),
    .WATCHDOG_TIMEOUT(wdt), .SLEEPING(slp), .CORE_HOLD(hold), .REG_INIT(init),
    .TIMEOUT_FLAG(to_f), .POWERDOWN_FLAG(pd_f), .OSC_MODE(osc), .WATCHDOG_ENABLE(wen),
    .BROWNOUT_ENABLE(ben), .PROTECT_ON(pon), .PROTECT_START(pst));

  // ----------------------------------------
  // clock, hold counter and hang guard
  // ----------------------------------------
  always #5 clk = ~clk;
  // counts held cycles and cuts a hang short
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (hold === 1'b1) hcnt <= hcnt + 1;
    if (cyc_cnt == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [13:0] prog_cfg(input logic [13:0] c, input logic [13:0] d, input logic [3:0] s);
    return c & ~({{6{s[1]}}, {8{s[0]}}} & ~d);
  endfunction : prog_cfg

  function automatic logic [10:0] prot_start(input logic [1:0] cp);
    return (cp == 2'h2) ? 11'h400 : (cp == 2'h1) ? 11'h200 : 11'h000;
  endfunction : prot_start

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    // ack ends this wait; only the bench-wide hang guard bounds it
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // waits for hold, then counts held cycles; -1 if hold never came
  task automatic settle(output int n, output logic ini);
    int k;
    k = 0;
    ini = 1'b0;
    while (hold !== 1'b1 && k < 30) begin
      @(posedge clk);
      k++;
    end
    n = 0;
    while (hold !== 1'b0 && n < 6000) begin
      if (init === 1'b1) ini = 1'b1;
      @(posedge clk);
      n++;
    end
    if (k >= 30) n = -1;
  endtask : settle

  task automatic power_on(output int n);
    logic ini;
    rst <= 1'b1;
    sup <= 1'b0;
    prog <= 1'b0;
    tick(10);
    rst <= 1'b0;
    tick(5);
    sup <= 1'b1;
    settle(n, ini);
  endtask : power_on

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    int n, h;
    logic ini;
    logic [13:0] c, d;
    logic [3:0] s;
    // power-on with blank word: brownout enable forces the delay
    power_on(n);
    chk(n >= POWERUP_TIMER && n <= POWERUP_TIMER + 12, 1);
    chk({to_f, pd_f}, 2'b11);
    wb(0, 16'h0004, 0, 4'hf);
    chk(rd, 32'h3);
    wb(0, 16'h801c, 0, 4'hf);
    chk(rd, 0);
    wb(1, 16'h801c, 0, 4'h3);
    wb(0, 16'h801c, 0, 4'hf);
    chk(rd, 0);
    chk({osc, wen, ben}, 4'hf);
    wb(0, 16'h0100, 0, 4'hf);
    chk(rd, 0);
    h = hcnt;
    sup <= 1'b0;
    tick(30);
    sup <= 1'b1;
    chk(hcnt - h, 0);
    $display("test power_on done");
    // short dip ignored, long dip resets, dip in the delay restarts it
    h = hcnt;
    dip <= 1'b1;
    tick(5);
    dip <= 1'b0;
    tick(20);
    chk(hcnt - h, 0);
    dip <= 1'b1;
    tick(30);
    chk({hold, init}, 2'b11);
    dip <= 1'b0;
    tick(20);
    dip <= 1'b1;
    tick(2);
    dip <= 1'b0;
    settle(n, ini);
    chk(n >= POWERUP_TIMER && n <= POWERUP_TIMER + 12, 1);
    wb(0, 16'h0004, 0, 4'hf);
    chk(rd, 32'h17);
    $display("test brownout done");
    // random programming, then a crystal word with brownout off
    for (int i = 0; i < 5; i++) begin
      power_on(n);
      prog <= 1'b1;
      tick(3);
      d = (i == 4) ? 14'h3f3d : 14'($random(seed));
      s = (i == 4) ? 4'h3 : 4'($random(seed));
      c = prog_cfg(14'h3fff, d, s);
      wb(1, 16'h801c, {18'h0, d}, s);
      tick(2);
      chk({osc, wen, ben}, {c[1:0], c[2], c[6]});
      chk(pon, c[5:4] != 2'h3);
      if (c[5:4] != 2'h3) chk(pst, prot_start(c[5:4]));
      wb(0, 16'h801c, 0, 4'hf);
      chk(rd, {18'h0, c & 14'h3f7f});
    end
    prog <= 1'b0;
    $display("test config done");
    // watchdog reset while running: no delay, no start-up count
    wdt <= 1'b1;
    tick(1);
    wdt <= 1'b0;
    settle(n, ini);
    chk(n >= 1 && n <= 6 && ini, 1);
    wb(0, 16'h0004, 0, 4'hf);
    chk(rd, 32'he);
    // watchdog wake from sleep: start-up count, registers kept
    slp <= 1'b1;
    wdt <= 1'b1;
    tick(1);
    wdt <= 1'b0;
    settle(n, ini);
    slp <= 1'b0;
    chk(n >= 4080 && n <= 4130, 1);
    chk(ini, 0);
    wb(0, 16'h0004, 0, 4'hf);
    chk(rd, 32'h10);
    $display("test watchdog done");
    // master clear while running, then in sleep
    for (int i = 0; i < 2; i++) begin
      slp <= i[0];
      h = hcnt;
      clr <= 1'b1;
      tick(150);
      clr <= 1'b0;
      tick(20);
      chk(hcnt - h, 0);
      clr <= 1'b1;
      tick(250);
      clr <= 1'b0;
      settle(n, ini);
      slp <= 1'b0;
      chk(n >= 1 && n <= 10 && ini, 1);
      wb(0, 16'h0004, 0, 4'hf);
      chk(rd, i ? 32'h9 : 32'h4);
    end
    $display("test master_clear done");
    // watchdog fuse cleared, brownout off: neither source resets
    prog <= 1'b1;
    tick(3);
    wb(1, 16'h801c, 32'h3f39, 4'h3);
    prog <= 1'b0;
    h = hcnt;
    wdt <= 1'b1;
    tick(1);
    wdt <= 1'b0;
    dip <= 1'b1;
    tick(40);
    dip <= 1'b0;
    tick(20);
    chk(hcnt - h, 0);
    chk(wen, 0);
    $display("test disables done");
    // fuses set while held at power-on: timer by its own fuse, else direct release
    for (int i = 0; i < 2; i++) begin
      rst <= 1'b1;
      sup <= 1'b0;
      tick(10);
      rst <= 1'b0;
      prog <= 1'b1;
      tick(3);
      wb(1, 16'h801c, i ? 32'h3fb7 : 32'h3fbf, 4'hf);
      prog <= 1'b0;
      sup <= 1'b1;
      settle(n, ini);
      chk(i ? (n >= POWERUP_TIMER && n <= POWERUP_TIMER + 12) : (n >= 1 && n <= 8), 1);
    end
    $display("test fuses done");
    stop_test();
  end
endmodule : rss_reset_sequencer_bench

`default_nettype wire
